// ==== src/mmssp_mem.sv ====
// Management byte store with a registered read port.
`timescale 1ns/10ps
module mmssp_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_r[raddr_i];
    end
endmodule // mmssp_mem

// ==== src/mmssp_pkg.sv ====
// Shared constants for the module-side management serial select port.
package mmssp_pkg;
    // Reference clock rate in MHz.
    localparam int CLK_MHZ = 125;
    // Longest clock hold-off in microseconds.
    localparam int STRETCH_MAX_US = 500;
    // Longest internal write completion in milliseconds.
    localparam int WRITE_TIME_MS = 40;
    // Longest bus release after deselect in milliseconds.
    localparam int DESELECT_ABORT_MS = 2;
    localparam int US_PER_MS = 1000;
    // Bytes accepted by one write sequence.
    localparam int PAGE_BYTES = 4;
    localparam int PAGE_IDX_W = 2;
    localparam logic [2:0] PAGE_FULL = 3'h4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MSB_IDX = 4'h7;
    localparam logic [6:0] DEF_DEV_ADDR = 7'h50;
    // Locations that advertise alternate select setup and hold times.
    localparam logic [7:0] ADV_SETUP_ADDR = 8'hfe;
    localparam logic [7:0] ADV_HOLD_ADDR = 8'hff;
    localparam logic [7:0] DEF_ALT_SETUP = 8'h02;
    localparam logic [7:0] DEF_ALT_HOLD = 8'h02;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_HOLD = 4'h3,
        ST_PTR = 4'h4,
        ST_WDATA = 4'h5,
        ST_WACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8
    } mmssp_state_e;
endpackage

// ==== src/mmssp_port.sv ====
// Module-side two-wire management port gated by the module select line.
// Rules for this block and for the host that drives it
// [RULE_01] Host leaves bus idle between sequences.
// [RULE_02] Clock held low at most the hold-off limit.
// [RULE_03] Writes of up to four bytes complete promptly.
// [RULE_04] Deselect abandons sequence and releases both lines.
// [RULE_05] Host selects module before starting a sequence.
// [RULE_06] Host keeps select steady after a sequence.
// [RULE_07] Multi-bit fields travel most significant bit first.
// [RULE_08] Alternate select setup and hold times are readable.
// [RULE_09] Only respond while selected; otherwise lines released.
`timescale 1ns/10ps
module mmssp_port import mmssp_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = mmssp_pkg::DEF_DEV_ADDR,
    parameter logic [7:0] ALT_SETUP_CODE = mmssp_pkg::DEF_ALT_SETUP,
    parameter logic [7:0] ALT_HOLD_CODE = mmssp_pkg::DEF_ALT_HOLD,
    parameter int STRETCH_CYC = mmssp_pkg::STRETCH_MAX_US * mmssp_pkg::CLK_MHZ,
    parameter int WRITE_CYC = mmssp_pkg::WRITE_TIME_MS * mmssp_pkg::US_PER_MS
        * mmssp_pkg::CLK_MHZ,
    parameter int ABORT_CYC = mmssp_pkg::DESELECT_ABORT_MS * mmssp_pkg::US_PER_MS
        * mmssp_pkg::CLK_MHZ
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic MODULE_SELECT_N_I,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_N_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    output logic WRITE_BUSY_O
);
    import mmssp_pkg::*;

    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic sel_s1_r, sel_s2_r;
    mmssp_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic rw_r, rd_ack_r;
    logic scl_oe_n_r, sda_oe_n_r;
    logic [7:0] wbuf_r [0:PAGE_BYTES-1];
    logic [2:0] wcnt_r, ccount_r, cidx_r;
    logic [7:0] wbase_r;
    logic busy_r;
    logic [31:0] stretch_cnt_r, wr_cnt_r, abort_cnt_r;
    logic [7:0] mem_rdata;
    logic selected, scl_rise, scl_fall, start_det, stop_det;
    logic byte_done, commit_go, stretch_lim, go_on, load_rd, wr_store;
    logic [7:0] rd_byte;

    // Advertised timing codes override the byte store at their locations.
    function automatic logic [7:0] adv_lookup(input logic [7:0] a, input logic [7:0] d);
        if (a == ADV_SETUP_ADDR) begin
            return ALT_SETUP_CODE;
        end else if (a == ADV_HOLD_ADDR) begin
            return ALT_HOLD_CODE;
        end
        return d;
    endfunction

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= SCL_I;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= SDA_I;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            sel_s1_r <= MODULE_SELECT_N_I;
            sel_s2_r <= sel_s1_r;
        end
    end

    always_comb begin
        selected = ~sel_s2_r;
        scl_rise = scl_s2_r & ~scl_d_r;
        scl_fall = ~scl_s2_r & scl_d_r;
        start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
        stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
        byte_done = scl_fall && (bit_cnt_r == BYTE_BITS);
        commit_go = selected && (start_det || stop_det) && (wcnt_r != 3'h0) && !busy_r;
        stretch_lim = (stretch_cnt_r >= 32'(STRETCH_CYC - 1));
        go_on = ((state_r == ST_ADDR_ACK) && scl_fall && !busy_r)
            || ((state_r == ST_HOLD) && (!busy_r || stretch_lim));
        load_rd = (go_on && rw_r) || ((state_r == ST_RACK) && scl_fall && rd_ack_r);
        wr_store = (state_r == ST_WDATA) && byte_done && (wcnt_r < PAGE_FULL);
        rd_byte = adv_lookup(ptr_r, mem_rdata); // RULE_08
    end

    // Sequence control and open-drain drive of both lines.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            rd_ack_r <= 1'b0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else if (!selected) begin
            state_r <= ST_IDLE; // RULE_04 RULE_09
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
            if (commit_go) begin
                ptr_r <= 8'(wbase_r + {5'h00, wcnt_r});
            end
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
            if (commit_go) begin
                ptr_r <= 8'(wbase_r + {5'h00, wcnt_r});
            end
        end else if (load_rd) begin
            shift_r <= rd_byte;
            sda_oe_n_r <= rd_byte[7]; // RULE_07
            ptr_r <= 8'(ptr_r + 8'h01);
            bit_cnt_r <= 4'h0;
            scl_oe_n_r <= 1'b1;
            state_r <= ST_RDATA;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    sda_oe_n_r <= 1'b1;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise && bit_cnt_r < BYTE_BITS) begin
                        shift_r <= {shift_r[6:0], sda_s2_r}; // RULE_07
                        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                    end else if (byte_done) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_r <= shift_r[0];
                                sda_oe_n_r <= 1'b0;
                                state_r <= ST_ADDR_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else if (state_r == ST_PTR) begin
                            ptr_r <= shift_r;
                            sda_oe_n_r <= 1'b0;
                            state_r <= ST_WACK;
                        end else if (wr_store) begin
                            sda_oe_n_r <= 1'b0;
                            state_r <= ST_WACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_r <= 1'b1;
                        if (busy_r) begin
                            scl_oe_n_r <= 1'b0; // RULE_02
                            state_r <= ST_HOLD;
                        end else begin
                            state_r <= ST_PTR;
                        end
                    end
                end
                ST_HOLD: begin
                    if (go_on) begin
                        scl_oe_n_r <= 1'b1; // RULE_02
                        state_r <= ST_PTR;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_n_r <= 1'b1;
                        state_r <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_r < MSB_IDX) begin
                            shift_r <= {shift_r[6:0], 1'b1};
                            sda_oe_n_r <= shift_r[6]; // RULE_07
                            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                        end else begin
                            sda_oe_n_r <= 1'b1;
                            state_r <= ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        rd_ack_r <= ~sda_s2_r;
                    end else if (scl_fall) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Page buffer and its commit into the byte store.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wcnt_r <= 3'h0;
            wbase_r <= 8'h00;
            ccount_r <= 3'h0;
            cidx_r <= 3'h0;
            busy_r <= 1'b0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                wbuf_r[i] <= 8'h00;
            end
        end else begin
            if (commit_go) begin
                busy_r <= 1'b1; // RULE_03
                ccount_r <= wcnt_r;
                cidx_r <= 3'h0;
                wcnt_r <= 3'h0;
            end else if (busy_r) begin
                cidx_r <= 3'(cidx_r + 3'h1);
                if (3'(cidx_r + 3'h1) == ccount_r) begin
                    busy_r <= 1'b0; // RULE_03
                end
            end
            if (!selected) begin
                wcnt_r <= 3'h0; // RULE_04
            end else if ((state_r == ST_PTR) && byte_done) begin
                wbase_r <= shift_r;
                wcnt_r <= 3'h0;
            end else if (wr_store) begin
                wbuf_r[wcnt_r[PAGE_IDX_W-1:0]] <= shift_r;
                wcnt_r <= 3'(wcnt_r + 3'h1);
            end
        end
    end

    // Hold-off, write and abort timers.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stretch_cnt_r <= 32'h0;
            wr_cnt_r <= 32'h0;
            abort_cnt_r <= 32'h0;
        end else begin
            stretch_cnt_r <= (state_r == ST_HOLD) ? 32'(stretch_cnt_r + 32'h1) : 32'h0;
            wr_cnt_r <= busy_r ? 32'(wr_cnt_r + 32'h1) : 32'h0;
            abort_cnt_r <= (!selected && !(scl_oe_n_r && sda_oe_n_r))
                ? 32'(abort_cnt_r + 32'h1) : 32'h0;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            SCL_OE_N_O <= 1'b1;
            SDA_OE_N_O <= 1'b1;
            WRITE_BUSY_O <= 1'b0;
        end else begin
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            SCL_OE_N_O <= scl_oe_n_r;
            SDA_OE_N_O <= sda_oe_n_r;
            WRITE_BUSY_O <= busy_r;
        end
    end

    mmssp_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
        .clk_i(REF_CLK_I),
        .we_i(busy_r),
        .waddr_i(8'(wbase_r + {5'h00, cidx_r})),
        .wdata_i(wbuf_r[cidx_r[PAGE_IDX_W-1:0]]),
        .raddr_i(ptr_r),
        .rdata_o(mem_rdata)
    );

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    a_stretch_bound: assert property (stretch_cnt_r < 32'(STRETCH_CYC)) // RULE_02
        else $error("clock held low beyond hold-off limit");
    a_hold_release: assert property ((state_r == ST_HOLD) && !busy_r && selected
        |=> scl_oe_n_r) // RULE_02
        else $error("clock not released after write finished");
    a_write_time: assert property (wr_cnt_r < 32'(WRITE_CYC)) // RULE_03
        else $error("write completion too slow");
    a_commit_done: assert property ($rose(busy_r) |-> ##[1:4] !busy_r) // RULE_03
        else $error("page commit did not finish in four cycles");
    a_abort_release: assert property (!selected |=> scl_oe_n_r && sda_oe_n_r) // RULE_04
        else $error("lines not released after deselect");
    a_abort_time: assert property (abort_cnt_r < 32'(ABORT_CYC)) // RULE_04
        else $error("bus release after deselect too slow");
    a_msb_first: assert property ((state_r == ST_RDATA) |-> sda_oe_n_r == shift_r[7]) // RULE_07
        else $error("read bit on the wire is not the top bit");
    a_advert_read: assert property (load_rd && selected && !start_det && !stop_det
        && (ptr_r == ADV_SETUP_ADDR) |=> shift_r == ALT_SETUP_CODE) // RULE_08
        else $error("advertised setup code not returned");
    a_idle_quiet: assert property ((state_r == ST_IDLE) |-> scl_oe_n_r && sda_oe_n_r) // RULE_09
        else $error("line driven while idle");

    c_write_commit: cover property ($rose(busy_r));
    c_read_byte: cover property ((state_r == ST_RACK) && scl_fall);
    c_stretch: cover property ((state_r == ST_HOLD) ##1 (state_r == ST_PTR));
    c_abort: cover property ((state_r == ST_ADDR_ACK) ##1 !selected);
endmodule // mmssp_port

// ==== tb/mmssp_host_model.sv ====
// Host controller model that drives the two-wire management bus and select line.
`timescale 1ns/10ps
module mmssp_host_model #(
    parameter int BUF_NS = 20000,
    parameter int SEL_NS = 2000000
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic sel_n_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        sel_n_o = 1'b1;
    end

    task automatic sel_on();
        sel_n_o = 1'b0;
        #(SEL_NS);
    endtask

    task automatic sel_off();
        #(SEL_NS);
        sel_n_o = 1'b1;
    endtask

    // Releases the clock and waits, bounded, while the module holds it low.
    task automatic clk_high();
        int i;
        scl_o = 1'b1;
        i = 0;
        while (scl_i !== 1'b1 && i < 100000) begin
            #8;
            i++;
        end
    endtask

    task automatic bit_cyc(input logic b, output logic r);
        #16 sda_o = b;
        #16 clk_high();
        #28 r = sda_i;
        #4 scl_o = 1'b0;
    endtask

    task automatic start();
        #32 sda_o = 1'b0;
        #32 scl_o = 1'b0;
    endtask

    task automatic stop();
        #16 sda_o = 1'b0;
        #16 clk_high();
        #32 sda_o = 1'b1;
        #(BUF_NS);
    endtask

    task automatic xfer(input logic [7:0] b, input logic a_out, output logic [7:0] r,
                        output logic a_in);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], r[i]);
        end
        bit_cyc(a_out, a_in);
    endtask

    task automatic write_seq(input logic [6:0] a, input logic [7:0] p, input logic [39:0] d,
                             input int n, output logic [6:0] acks);
        logic [7:0] r;
        acks = '1;
        start();
        xfer({a, 1'b0}, 1'b1, r, acks[6]);
        xfer(p, 1'b1, r, acks[5]);
        for (int k = 0; k < n; k++) begin
            xfer(d[39-8*k -: 8], 1'b1, r, acks[4-k]);
        end
        stop();
    endtask

    task automatic read_seq(input logic [6:0] a, input int n, output logic [39:0] d,
                            output logic ack);
        logic [7:0] r;
        logic x;
        d = '0;
        start();
        xfer({a, 1'b1}, 1'b1, r, ack);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, r, x);
            d = {d[31:0], r};
        end
        stop();
    endtask

    // Deselects while the module is driving its address acknowledge.
    task automatic abort_seq(input logic [6:0] a);
        logic r;
        start();
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(i == 0 ? 1'b0 : a[i-1], r);
        end
        #16 sda_o = 1'b1;
        #24 sel_n_o = 1'b1;
    endtask

    task automatic idle();
        #32 scl_o = 1'b1;
        #32 sda_o = 1'b1;
        #(BUF_NS);
    endtask
endmodule // mmssp_host_model

// ==== tb/mmssp_port_test.sv ====
// Self-checking bench for the management serial select port.
`timescale 1ns/10ps
module mmssp_port_test;
    import mmssp_pkg::*;
    localparam int SHORT_CYC = 64;
    localparam logic [7:0] SETUP_CODE = 8'h3c;
    localparam logic [7:0] HOLD_CODE = 8'hc3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic h_scl, h_sda, sel_n, scl_w, sda_w;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, busy;
    int num_errors = 0;
    int n_checks = 0;
    int busy_cnt = 0;
    logic [15:0] lfsr_r = 16'h0008;
    logic [7:0] shadow [256];
    logic [6:0] acks;
    logic [39:0] d;

    assign scl_w = h_scl & (scl_oe_n | scl_out);
    assign sda_w = h_sda & (sda_oe_n | sda_out);

    always #4 clk = ~clk;
    always @(posedge clk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

    mmssp_port #(.ALT_SETUP_CODE(SETUP_CODE), .ALT_HOLD_CODE(HOLD_CODE),
        .STRETCH_CYC(SHORT_CYC), .WRITE_CYC(SHORT_CYC), .ABORT_CYC(SHORT_CYC)) uut (
        .REF_CLK_I(clk), .RST_I(rst), .MODULE_SELECT_N_I(sel_n), .SCL_I(scl_w),
        .SCL_O(scl_out), .SCL_OE_N_O(scl_oe_n), .SDA_I(sda_w), .SDA_O(sda_out),
        .SDA_OE_N_O(sda_oe_n), .WRITE_BUSY_O(busy));

    mmssp_host_model #(.BUF_NS(20000), .SEL_NS(4000)) host (
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda), .sel_n_o(sel_n));

    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [7:0] exp_byte(input logic [7:0] p);
        if (p == 8'hfe) return SETUP_CODE;
        if (p == 8'hff) return HOLD_CODE;
        return shadow[p];
    endfunction

    task automatic fail(input string msg);
        num_errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) fail(what);
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) fail(what);
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_write(input logic [7:0] p, input logic [39:0] v, input int n);
        busy_cnt = 0;
        host.write_seq(DEF_DEV_ADDR, p, v, n, acks);
        chk_bit(acks[6], 1'b0, "address not acknowledged");
        chk_bit(acks[5], 1'b0, "pointer not acknowledged");
        for (int k = 0; k < n; k++) begin
            chk_bit(acks[4-k], k >= PAGE_BYTES, "data acknowledge wrong");
            if (k < PAGE_BYTES) shadow[p + 8'(k)] = v[39-8*k -: 8];
        end
        if (n > 0) chk_bit(busy_cnt == (n > 4 ? 4 : n), 1'b1, "commit length wrong");
    endtask

    task automatic do_read(input logic [7:0] p, input int n);
        logic a;
        do_write(p, 40'h0, 0);
        host.read_seq(DEF_DEV_ADDR, n, d, a);
        chk_bit(a, 1'b0, "read address not acknowledged");
        for (int k = 0; k < n; k++) begin
            chk_byte(d[8*(n-1-k) +: 8], exp_byte(p + 8'(k)), "read data wrong");
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Host timing runs off the falling edge so no pin moves on a sampling edge.
        @(negedge clk);
        host.sel_on();
        do_write(8'hfa, 40'h8001ff0000, 4);
        do_read(8'hfa, 4);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 5; i++) begin
                lfsr_r = lfsr_step(lfsr_r);
                d = {d[31:0], lfsr_r[7:0]};
            end
            do_write({1'b0, lfsr_r[14:8]}, d, r + 1);
            do_read({1'b0, lfsr_r[14:8]}, r + 1);
        end
        do_write(8'h20, 40'h1122334455, 5);
        do_read(8'h20, 4);
        do_read(8'hfe, 2);
        host.write_seq(DEF_DEV_ADDR ^ 7'h01, 8'h20, 40'h0, 1, acks);
        chk_bit(acks[6], 1'b1, "foreign address acknowledged");
        do_read(8'h20, 1);
        host.sel_off();
        host.sel_on();
        host.abort_seq(DEF_DEV_ADDR);
        chk_bit(sda_oe_n, 1'b0, "no acknowledge before deselect");
        for (int k = 0; k < SHORT_CYC && (sda_oe_n !== 1'b1 || scl_oe_n !== 1'b1); k++) begin
            @(negedge clk);
        end
        chk_bit(sda_oe_n, 1'b1, "data line not released");
        chk_bit(scl_oe_n, 1'b1, "clock line not released");
        host.idle();
        busy_cnt = 0;
        host.write_seq(DEF_DEV_ADDR, 8'h20, 40'h9900000000, 1, acks);
        chk_bit(acks[6], 1'b1, "answered while deselected");
        chk_bit(busy_cnt == 0, 1'b1, "committed while deselected");
        host.sel_on();
        do_read(8'h20, 1);
        host.sel_off();
        complete_run();
    end

    initial begin
        #700000;
        fail("watchdog expired");
        complete_run();
    end
endmodule // mmssp_port_test
